/* File: pkg/jds_defines.vh */
// Shared constants for the jet drop firing sequencer
`ifndef JDS_DEFINES_VH
`define JDS_DEFINES_VH

////////////////////////////////////////////////////////////////////////
// Timing
`define JDS_CLK_PERIOD_NS 4
`define JDS_TICK_NS       100000
`define JDS_TICK_CYCLES   (`JDS_TICK_NS / `JDS_CLK_PERIOD_NS)

////////////////////////////////////////////////////////////////////////
// Recipe store layout: word index = {recipe[2:0], field[2:0]}
`define JDS_NUM_RECIPES   3'h6
`define JDS_F_MODE        3'h0
`define JDS_F_DROPS       3'h1
`define JDS_F_REFILL      3'h2
`define JDS_F_DWELL       3'h3
`define JDS_F_EXTRA       3'h4
`define JDS_F_PRESS       3'h5
`define JDS_F_COMP        3'h6
`define JDS_F_RSVD        3'h7
`define JDS_MODE_BIT      0
`define JDS_MODE_PULSE    1'b0
`define JDS_MODE_LEVEL    1'b1

////////////////////////////////////////////////////////////////////////
// Register word addresses
`define JDS_A_RECIPE_END  6'h30
`define JDS_A_SELECT      6'h30
`define JDS_A_CMD         6'h31
`define JDS_A_STATUS      6'h32
`define JDS_A_DONE        6'h33
`define JDS_A_TIMER       6'h34

////////////////////////////////////////////////////////////////////////
// Command register bits (write one to act)
`define JDS_C_DROP_INC    0
`define JDS_C_DROP_DEC    1
`define JDS_C_PRESS_INC   2
`define JDS_C_PRESS_DEC   3
`define JDS_C_MODE_TOG    4
`define JDS_C_JET_TOG     5

////////////////////////////////////////////////////////////////////////
// Status register bits
`define JDS_S_BUSY        0
`define JDS_S_VALVE       1
`define JDS_S_MANUAL      2
`define JDS_S_FLUID       3
`define JDS_S_LEVEL       4
`define JDS_S_RECIPE_LO   5
`define JDS_S_STATE_LO    8

////////////////////////////////////////////////////////////////////////
// Reset values of every recipe, then the drop and pressure limits
`define JDS_RST_MODE      16'h0000
`define JDS_RST_DROPS     16'h0001
`define JDS_RST_REFILL    16'h000A
`define JDS_RST_DWELL     16'h000A
`define JDS_RST_EXTRA     16'h0000
`define JDS_RST_PRESS     16'h00C8
`define JDS_RST_COMP      16'h0000
`define JDS_DROPS_MAX     16'hFFFF
`define JDS_PRESS_MAX     16'hFFFF

`endif

/* File: hw/jds_sync.v */
// Two-stage synchroniser for asynchronous input pins
`timescale 1ns/1ns
module jds_sync #(
	parameter W = 1
) (
	input  wire         clock,
	input  wire         nrst,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] stage1;

	always @(posedge clock) begin
		if (!nrst) begin
			stage1 <= {W{1'b0}};
			dout   <= {W{1'b0}};
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule // jds_sync

/* File: hw/jds_tick.v */
// Divider giving one-cycle 0.1 ms tick enables
`timescale 1ns/1ns
module jds_tick #(
	parameter CYCLES = 25000,
	parameter CW     = 16
) (
	input  wire clock,
	input  wire nrst,
	input  wire clear,
	output reg  tick
);
	localparam integer  LAST_I = CYCLES - 1;
	localparam [CW-1:0] LAST   = LAST_I[CW-1:0];
	reg [CW-1:0] count;

	// Clear realigns the tick so a sequence starts on a full period
	always @(posedge clock) begin
		if (!nrst || clear) begin
			count <= {CW{1'b0}};
			tick  <= 1'b0;
		end else if (count == LAST) begin
			count <= {CW{1'b0}};
			tick  <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule // jds_tick

/* File: hw/jds_sequencer.v */
// Jet drop firing sequencer: recipe store, drop timing, valve drive
//
// What this block does
// - Manual button fires current recipe immediately
// - Six recipes, one selectable as current
// - Each recipe keeps all its own settings
// - Trigger mode pulse or level, toggleable
// - Pulse trigger dispenses drop count, zero giving one drop
// - Level mode fires while trigger held
// - Button in level mode acts as pulse
// - Drop count per trigger, step one
// - Valve open for refill time, 0.1 ms
// - Valve closed for dwell time, 0.1 ms
// - Extra open time: pulse all, level first
// - Manual valve open/close toggle with status
// - Pressure setpoint steps by 0.1 psi
// - Fluid air switch gates pressure immediately
// - Busy status output to robot
// - Stop input aborts firing sequence
//
// Our own choices: the register addresses and the strobed register port.
`include "jds_defines.vh"
`timescale 1ns/1ns
module jds_sequencer #(
	parameter TICK_CYCLES = `JDS_TICK_CYCLES,
	parameter DW          = 16
) (
	input  wire          clock,
	input  wire          nrst,
	input  wire [5:0]    addr,
	input  wire [DW-1:0] wrData,
	input  wire          wrStrobe,
	input  wire          rdStrobe,
	output reg  [DW-1:0] rdData,
	input  wire [5:0]    recipeLine,
	input  wire          stopIn,
	input  wire          fireButton,
	input  wire          fluidAirSwitch,
	output reg           busy,
	output reg           firingLed,
	output reg           jetValve,
	output reg           jetOpenStatus,
	output reg           fluidAirEnable,
	output reg  [DW-1:0] pressureSetpoint
);
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_PREP  = 2'h1;
	localparam [1:0] ST_OPEN  = 2'h2;
	localparam [1:0] ST_CLOSE = 2'h3;
	// Spare bit so refill plus extra cannot wrap
	localparam       CW       = DW + 1;

	////////////////////////////////////////////////////////////////////
	// Input synchronisers and edge detection
	wire [8:0] syncIn;
	wire       tick;
	reg  [6:0] prevIn;
	wire [5:0] lineLvl   = syncIn[5:0];
	wire       stopLvl   = syncIn[6];
	wire       buttonLvl = syncIn[7];
	wire       fluidLvl  = syncIn[8];
	wire [5:0] lineRise  = lineLvl & ~prevIn[5:0];
	wire       buttonRise = buttonLvl & ~prevIn[6];

	jds_sync #(
		.W (9)
	) u_sync (
		.clock (clock),
		.nrst  (nrst),
		.din   ({fluidAirSwitch, fireButton, stopIn, recipeLine}),
		.dout  (syncIn)
	);

	// Starts low like every idle pin, so reset makes no false edge
	always @(posedge clock) begin
		if (!nrst) begin
			prevIn <= 7'h00;
		end else begin
			prevIn <= {buttonLvl, lineLvl};
		end
	end

	////////////////////////////////////////////////////////////////////
	// State and recipe store
	reg [DW-1:0] recipeMem [0:47];
	reg [2:0]    curRecipe;
	reg          manualOpen;
	reg [1:0]    state;
	reg [CW-1:0] cnt;
	reg [DW-1:0] dropsLeft;
	reg [DW-1:0] dropsDone;
	reg          firstDrop;
	reg          levelRun;
	reg [2:0]    activeLine;

	reg [1:0]    next_state;
	reg [CW-1:0] next_cnt;
	reg [DW-1:0] next_dropsLeft;
	reg          next_firstDrop;
	reg          next_levelRun;
	reg [2:0]    next_activeLine;
	reg          startNow;
	reg [2:0]    startRecipe;

	wire [DW-1:0] curMode   = recipeMem[{curRecipe, `JDS_F_MODE}];
	wire [DW-1:0] curDrops  = recipeMem[{curRecipe, `JDS_F_DROPS}];
	wire [DW-1:0] curRefill = recipeMem[{curRecipe, `JDS_F_REFILL}];
	wire [DW-1:0] curDwell  = recipeMem[{curRecipe, `JDS_F_DWELL}];
	wire [DW-1:0] curExtra  = recipeMem[{curRecipe, `JDS_F_EXTRA}];
	wire [DW-1:0] curPress  = recipeMem[{curRecipe, `JDS_F_PRESS}];

	wire [CW-1:0] openFirst = {1'b0, curRefill} + {1'b0, curExtra};
	wire [CW-1:0] openNext  = levelRun ? {1'b0, curRefill} : openFirst;
	// Index past the six lines reads as released
	wire          lineHeld  = (activeLine < `JDS_NUM_RECIPES) ? lineLvl[activeLine] : 1'b0;
	wire          moreDrops = levelRun ? lineHeld : (dropsLeft > 16'h0001);

	// With both bits set, increment wins below the maximum and decrement wins at it
	wire          cmdWrite  = wrStrobe && (addr == `JDS_A_CMD);

	// Lowest index wins when several lines rise together
	function [2:0] firstLine;
		input [5:0] v;
		integer     i;
		begin
			firstLine = 3'h0;
			for (i = 5; i >= 0; i = i - 1) begin
				if (v[i]) begin
					firstLine = i[2:0];
				end
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Recipe store, selection and manual controls
	integer r;
	always @(posedge clock) begin
		if (!nrst) begin
			for (r = 0; r < 6; r = r + 1) begin
				recipeMem[r * 8 + 0] <= `JDS_RST_MODE;
				recipeMem[r * 8 + 1] <= `JDS_RST_DROPS;
				recipeMem[r * 8 + 2] <= `JDS_RST_REFILL;
				recipeMem[r * 8 + 3] <= `JDS_RST_DWELL;
				recipeMem[r * 8 + 4] <= `JDS_RST_EXTRA;
				recipeMem[r * 8 + 5] <= `JDS_RST_PRESS;
				recipeMem[r * 8 + 6] <= `JDS_RST_COMP;
				recipeMem[r * 8 + 7] <= {DW{1'b0}};
			end
			curRecipe  <= 3'h0;
			manualOpen <= 1'b0;
		end else begin
			// Reserved field of each recipe stays zero
			if (wrStrobe && addr < `JDS_A_RECIPE_END && addr[2:0] != `JDS_F_RSVD) begin
				recipeMem[addr] <= wrData;
			end
			if (cmdWrite) begin
				if (wrData[`JDS_C_DROP_INC] && curDrops != `JDS_DROPS_MAX) begin
					recipeMem[{curRecipe, `JDS_F_DROPS}] <= curDrops + 1'b1;
				end else if (wrData[`JDS_C_DROP_DEC] && curDrops > 16'h0001) begin
					recipeMem[{curRecipe, `JDS_F_DROPS}] <= curDrops - 1'b1;
				end
				if (wrData[`JDS_C_PRESS_INC] && curPress != `JDS_PRESS_MAX) begin
					recipeMem[{curRecipe, `JDS_F_PRESS}] <= curPress + 1'b1;
				end else if (wrData[`JDS_C_PRESS_DEC] && curPress != 16'h0000) begin
					recipeMem[{curRecipe, `JDS_F_PRESS}] <= curPress - 1'b1;
				end
				if (wrData[`JDS_C_MODE_TOG]) begin
					recipeMem[{curRecipe, `JDS_F_MODE}] <= curMode ^ 16'h0001;
				end
				if (wrData[`JDS_C_JET_TOG]) begin
					manualOpen <= ~manualOpen;
				end
			end
			// A line start beats a bus select in the same cycle
			// Current recipe select
			if (startNow) begin
				curRecipe <= startRecipe;
			end else if (wrStrobe && addr == `JDS_A_SELECT && wrData < 16'h0006) begin
				curRecipe <= wrData[2:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Firing sequence next-state logic
	always @* begin
		next_state      = state;
		next_cnt        = cnt;
		next_dropsLeft  = dropsLeft;
		next_firstDrop  = firstDrop;
		next_levelRun   = levelRun;
		next_activeLine = activeLine;
		startNow        = 1'b0;
		startRecipe     = curRecipe;
		if (cnt != {CW{1'b0}} && tick) begin
			next_cnt = cnt - 1'b1;
		end
		case (state)
			ST_IDLE: begin
				if (!stopLvl && buttonRise) begin
					startNow      = 1'b1;
					next_levelRun = 1'b0;
					next_state    = ST_PREP;
				end else if (!stopLvl && lineRise != 6'h00) begin
					startNow        = 1'b1;
					startRecipe     = firstLine(lineRise);
					next_activeLine = startRecipe;
					next_levelRun   = recipeMem[{startRecipe, `JDS_F_MODE}][`JDS_MODE_BIT];
					next_state      = ST_PREP;
				end
			end
			ST_PREP: begin
				next_dropsLeft = (curDrops == 16'h0000) ? 16'h0001 : curDrops;
				next_firstDrop = 1'b1;
				next_cnt       = openFirst;
				next_state     = ST_OPEN;
			end
			ST_OPEN: begin
				if (cnt == {CW{1'b0}}) begin
					next_cnt   = {1'b0, curDwell};
					next_state = ST_CLOSE;
				end
			end
			ST_CLOSE: begin
				if (cnt == {CW{1'b0}}) begin
					if (moreDrops) begin
						next_dropsLeft = dropsLeft - 1'b1;
						next_firstDrop = 1'b0;
						next_cnt       = openNext;
						next_state     = ST_OPEN;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// Manual valve is left as the operator set it
		// Stop aborts at once
		if (stopLvl) begin
			next_state = ST_IDLE;
			next_cnt   = {CW{1'b0}};
		end
	end

	// Divider restarts with each sequence so phases are whole ticks
	jds_tick #(
		.CYCLES (TICK_CYCLES),
		// Wide enough for the full-speed tick count
		.CW     (24)
	) u_tick (
		.clock (clock),
		.nrst  (nrst),
		.clear (startNow),
		.tick  (tick)
	);

	////////////////////////////////////////////////////////////////////
	// Sequencer registers and outputs
	always @(posedge clock) begin
		if (!nrst) begin
			state            <= ST_IDLE;
			cnt              <= {CW{1'b0}};
			dropsLeft        <= {DW{1'b0}};
			dropsDone        <= {DW{1'b0}};
			firstDrop        <= 1'b0;
			levelRun         <= 1'b0;
			activeLine       <= 3'h0;
			busy             <= 1'b0;
			firingLed        <= 1'b0;
			jetValve         <= 1'b0;
			jetOpenStatus    <= 1'b0;
			fluidAirEnable   <= 1'b0;
			pressureSetpoint <= {DW{1'b0}};
		end else begin
			state      <= next_state;
			cnt        <= next_cnt;
			dropsLeft  <= next_dropsLeft;
			firstDrop  <= next_firstDrop;
			levelRun   <= next_levelRun;
			activeLine <= next_activeLine;
			// Drops started in this sequence, for read-back
			if (startNow) begin
				dropsDone <= {DW{1'b0}};
			end else if (next_state == ST_OPEN && state != ST_OPEN) begin
				dropsDone <= dropsDone + 1'b1;
			end
			busy             <= (next_state != ST_IDLE);
			firingLed        <= (next_state != ST_IDLE);
			jetValve         <= (next_state == ST_OPEN) || manualOpen;
			jetOpenStatus    <= manualOpen;
			fluidAirEnable   <= fluidLvl;
			pressureSetpoint <= curPress;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register reads, data in the cycle after the strobe
	// Reserved field and unmapped words read as zero
	always @(posedge clock) begin
		if (!nrst) begin
			rdData <= {DW{1'b0}};
		end else if (rdStrobe) begin
			if (addr < `JDS_A_RECIPE_END) begin
				rdData <= (addr[2:0] == `JDS_F_RSVD) ? {DW{1'b0}} : recipeMem[addr];
			end else begin
				case (addr)
					`JDS_A_SELECT: rdData <= {13'h0000, curRecipe};
					// Bit ten: sequence still on its first drop
					`JDS_A_STATUS: rdData <= {5'h00, firstDrop, state, curRecipe,
						curMode[`JDS_MODE_BIT], fluidAirEnable, manualOpen,
						jetValve, busy};
					`JDS_A_DONE:   rdData <= dropsDone;
					`JDS_A_TIMER:  rdData <= cnt[DW-1:0];
					default:       rdData <= {DW{1'b0}};
				endcase
			end
		end
	end
endmodule // jds_sequencer

/* File: verification/jds_robot.sv */
// Robot model driving recipe trigger and stop lines
`timescale 1ns/1ns
module jds_robot (
	input  wire       clock,
	output reg  [5:0] recipeLine,
	output reg        stopIn
);
	initial begin
		recipeLine = 6'h00;
		stopIn     = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// hold one line
	task fire(input int i, input int n);
		@(posedge clock);
		recipeLine[i] <= 1'b1;
		repeat (n) @(posedge clock);
		recipeLine[i] <= 1'b0;
	endtask
	task halt(input int n);
		@(posedge clock);
		stopIn <= 1'b1;
		repeat (n) @(posedge clock);
		stopIn <= 1'b0;
	endtask
endmodule // jds_robot

/* File: verification/jds_sequencer_assertions.sv */
// Port checker for the jet drop sequencer
`timescale 1ns/1ns
`include "jds_defines.vh"
module jds_sequencer_checker (
	input wire        clock,
	input wire        nrst,
	input wire [5:0]  addr,
	input wire [15:0] wrData,
	input wire        wrStrobe,
	input wire        stopIn,
	input wire        fluidAirSwitch,
	input wire        busy,
	input wire        firingLed,
	input wire        jetValve,
	input wire        jetOpenStatus,
	input wire        fluidAirEnable,
	input wire [15:0] pressureSetpoint
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// Stale value if two press writes come back to back
	property press_up;
		(wrStrobe && addr == `JDS_A_CMD && wrData[`JDS_C_PRESS_INC]
			&& pressureSetpoint != 16'hFFFF)
			|-> ##2 pressureSetpoint == $past(pressureSetpoint, 2) + 16'h0001;
	endproperty
	////////////////////////////////////////////////////////////////
	led_busy_a: assert property (firingLed == busy)
		else $error("indicator differs from busy");
	led_valve_a: assert property (jetValve && !jetOpenStatus |-> firingLed)
		else $error("valve fired with indicator dark");
	valve_in_seq_a: assert property (jetValve && !jetOpenStatus && !$past(jetOpenStatus)
		|-> busy)
		else $error("valve open outside a sequence");
	stop_abort_a: assert property (stopIn [*6] |-> !busy)
		else $error("busy survives stop");
	fluid_follow_a: assert property ($past(nrst, 4) |->
		fluidAirEnable == $past(fluidAirSwitch, 3))
		else $error("fluid enable lags switch");
	valve_after_busy_a: assert property ($rose(busy) |=> jetValve)
		else $error("no open phase after start");
	busy_hold_a: assert property ($rose(busy) && !stopIn |-> busy [*3])
		else $error("busy too short");
	manual_open_a: assert property (jetOpenStatus && $past(jetOpenStatus) |-> jetValve)
		else $error("manual open not on valve");
	press_step_a: assert property (press_up)
		else $error("pressure step not one");
	start_c: cover property ($rose(busy));
	abort_c: cover property (busy && stopIn);
	manual_c: cover property ($rose(jetOpenStatus));
endmodule // jds_sequencer_checker

bind jds_sequencer jds_sequencer_checker jds_sequencer_checker_inst (.clock(clock),
	.nrst(nrst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .stopIn(stopIn),
	.fluidAirSwitch(fluidAirSwitch), .busy(busy), .firingLed(firingLed),
	.jetValve(jetValve), .jetOpenStatus(jetOpenStatus), .fluidAirEnable(fluidAirEnable),
	.pressureSetpoint(pressureSetpoint));

/* File: verification/jds_sequencer_tb.sv */
// Bench for the jet drop firing sequencer
`timescale 1ns/1ns
`include "jds_defines.vh"
module jds_sequencer_tb;
	logic        clock, nrst, wrStrobe, rdStrobe, fireButton, fluidAirSwitch;
	logic [5:0]  addr, recipeLine;
	logic [15:0] wrData, rdData, pressureSetpoint;
	logic        stopIn, busy, firingLed, jetValve, jetOpenStatus, fluidAirEnable;
	int          bad_count = 0, compares = 0, drops, cur = 0, len0, len1, busyLen;
	logic [15:0] rst [7] = '{`JDS_RST_MODE, `JDS_RST_DROPS, `JDS_RST_REFILL,
		`JDS_RST_DWELL, `JDS_RST_EXTRA, `JDS_RST_PRESS, `JDS_RST_COMP};

	jds_sequencer #(.TICK_CYCLES(4)) jds_sequencer_inst (.clock(clock), .nrst(nrst),
		.addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
		.rdData(rdData), .recipeLine(recipeLine), .stopIn(stopIn),
		.fireButton(fireButton), .fluidAirSwitch(fluidAirSwitch), .busy(busy),
		.firingLed(firingLed), .jetValve(jetValve), .jetOpenStatus(jetOpenStatus),
		.fluidAirEnable(fluidAirEnable), .pressureSetpoint(pressureSetpoint));
	jds_robot jds_robot_inst (.clock(clock), .recipeLine(recipeLine), .stopIn(stopIn));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////
	// Drop lengths measured on the valve pin
	always @(posedge clock) begin
		if (busy === 1'b1) busyLen++;
		if (jetValve === 1'b1) cur++;
		else if (cur > 0) begin
			drops++;
			if (drops == 1) len0 = cur;
			if (drops == 2) len1 = cur;
			cur = 0;
		end
	end
	////////////////////////////////////////////////////////////////
	task give_verdict;
		$display("compares %0d bad %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task chkr(input int got, input int lo, input int hi);
		compares++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("BAD %0t count %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clock);
		wrStrobe <= 1'b0;
	endtask
	task rd(input logic [5:0] a, input logic [15:0] e);
		@(posedge clock);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clock);
		rdStrobe <= 1'b0;
		#1 chk(rdData, e);
	endtask
	task cmd(input int b);
		wr(`JDS_A_CMD, 16'h0001 << b);
	endtask
	task prog(input logic [2:0] r, input logic [15:0] m, n, o, c, x);
		wr({r, `JDS_F_MODE}, m);
		wr({r, `JDS_F_DROPS}, n);
		wr({r, `JDS_F_REFILL}, o);
		wr({r, `JDS_F_DWELL}, c);
		wr({r, `JDS_F_EXTRA}, x);
	endtask
	task clr;
		drops = 0;
		busyLen = 0;
		len0 = 0;
		len1 = 0;
	endtask
	// Bounded wait, then room for the last drop to land
	task idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		if (n >= 3000) begin
			bad_count++;
			$display("BAD %0t stuck busy", $time);
		end
		repeat (4) @(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		bad_count++;
		$display("BAD %0t watchdog", $time);
		give_verdict();
	end

	initial begin
		addr = 6'h00;
		wrData = 16'h0000;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		fireButton = 1'b0;
		fluidAirSwitch = 1'b0;
		nrst = 1'b0;
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		for (int r = 0; r < 6; r++)
			for (int f = 0; f < 7; f++)
				rd(6'(r * 8 + f), rst[f]);
		chk(pressureSetpoint, `JDS_RST_PRESS);
		$display("test reset done");
		// Second trigger lands mid-sequence and must be dropped
		prog(3'h1, 16'h0000, 16'h0003, 16'h0002, 16'h0003, 16'h0001);
		clr();
		jds_robot_inst.fire(1, 6);
		repeat (20) @(posedge clock);
		jds_robot_inst.fire(2, 6);
		idle();
		chkr(drops, 3, 3);
		chkr(len0, 11, 13);
		chkr(len1, 11, 13);
		chkr(busyLen, 68, 80);
		rd(`JDS_A_SELECT, 16'h0001);
		rd(`JDS_A_DONE, 16'h0003);
		$display("test pulse done");
		prog(3'h2, 16'h0001, 16'h0002, 16'h0002, 16'h0002, 16'h0002);
		clr();
		jds_robot_inst.fire(2, 60);
		idle();
		chkr(drops, 3, 5);
		chkr(len0, 15, 17);
		chkr(len1, 7, 9);
		$display("test level done");
		clr();
		@(posedge clock);
		fireButton <= 1'b1;
		repeat (6) @(posedge clock);
		fireButton <= 1'b0;
		idle();
		chkr(drops, 2, 2);
		chkr(len1, 15, 17);
		$display("test button done");
		wr(`JDS_A_SELECT, 16'h0000);
		cmd(`JDS_C_DROP_DEC);
		rd({3'h0, `JDS_F_DROPS}, 16'h0001);
		cmd(`JDS_C_DROP_INC);
		rd({3'h0, `JDS_F_DROPS}, 16'h0002);
		cmd(`JDS_C_MODE_TOG);
		rd({3'h0, `JDS_F_MODE}, 16'h0001);
		cmd(`JDS_C_MODE_TOG);
		rd({3'h0, `JDS_F_MODE}, 16'h0000);
		cmd(`JDS_C_PRESS_INC);
		rd({3'h0, `JDS_F_PRESS}, 16'h00C9);
		chk(pressureSetpoint, 16'h00C9);
		cmd(`JDS_C_PRESS_DEC);
		rd({3'h0, `JDS_F_PRESS}, 16'h00C8);
		cmd(`JDS_C_JET_TOG);
		rd(`JDS_A_STATUS, 16'h0006);
		chk(jetOpenStatus, 1'b1);
		cmd(`JDS_C_JET_TOG);
		rd(`JDS_A_STATUS, 16'h0000);
		chk(jetOpenStatus, 1'b0);
		$display("test command done");
		clr();
		jds_robot_inst.fire(1, 6);
		repeat (8) @(posedge clock);
		#1 chk(firingLed, 1'b1);
		jds_robot_inst.halt(8);
		#1 chk(busy, 1'b0);
		chk(firingLed, 1'b0);
		chkr(drops, 0, 1);
		$display("test stop done");
		@(posedge clock);
		fluidAirSwitch <= 1'b1;
		repeat (5) @(posedge clock);
		#1 chk(fluidAirEnable, 1'b1);
		wr(`JDS_A_SELECT, 16'h0007);
		rd(`JDS_A_SELECT, 16'h0001);
		rd(6'h3F, 16'h0000);
		rd(`JDS_A_TIMER, 16'h0000);
		wr({3'h0, `JDS_F_RSVD}, 16'h1234);
		rd({3'h0, `JDS_F_RSVD}, 16'h0000);
		$display("test misc done");
		give_verdict();
	end
endmodule // jds_sequencer_tb
